// [dasp_pkg.sv]
/*
 * Package for the dual asynchronous serial port block: frame constants,
 * baud defaults, state encodings and the user-side carrier structs.
 * Assumes a single 100 MHz clock shared by every user of the package.
 */
package dasp_pkg;

	// ---------------------------------------------------------------
	// clock and frame
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned DATA_BITS    = 8;
	localparam int unsigned BAUD_MIN     = 300;
	localparam int unsigned BAUD_MAX     = 256_000;
	localparam int unsigned BAUD_DEFAULT = 115_200;
	localparam int unsigned DIV_W        = 20;
	localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / BAUD_DEFAULT);
	localparam logic [DIV_W-1:0] DIV_MIN   = DIV_W'(CLK_HZ / BAUD_MAX);
	localparam logic [DIV_W-1:0] DIV_MAX   = DIV_W'(CLK_HZ / BAUD_MIN);
	localparam logic        LINE_IDLE    = 1'b1;
	localparam logic        START_LEVEL  = 1'b0;
	localparam logic        STOP_LEVEL   = 1'b1;
	localparam int unsigned RX_DEPTH     = 16;

	// ---------------------------------------------------------------
	// state machines
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		DASP_TX_IDLE  = 4'h1,
		DASP_TX_START = 4'h2,
		DASP_TX_DATA  = 4'h4,
		DASP_TX_STOP  = 4'h8
	} dasp_tx_state_type;

	typedef enum logic [3:0] {
		DASP_RX_IDLE  = 4'h1,
		DASP_RX_START = 4'h2,
		DASP_RX_DATA  = 4'h4,
		DASP_RX_STOP  = 4'h8
	} dasp_rx_state_type;

	// ---------------------------------------------------------------
	// user-side carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] baud_div;
		logic             buffered;
		logic             err_clear;
	} dasp_cfg_type;

	typedef struct packed {
		logic frame_err;
		logic overflow;
		logic tx_busy;
		logic [4:0] rx_count;
	} dasp_status_type;

endpackage

// [dasp_serial_peer.sv]
/* external serial device model for one port: sends frames into the
   device receive pin and decodes frames from its transmit pin.
   assumes the bench sets div to the port's clocks per bit. */
`timescale 1ns/1ps
module dasp_serial_peer (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	int unsigned div       = 390;
	int          stop_errs = 0;
	logic [7:0]  got_q[$];
	logic [7:0]  rx_byte;

	// ---------------------------------------------------------------
	// sender, entered just after a rising edge
	// ---------------------------------------------------------------
	initial line_out = 1'b1;
	task automatic send_byte(input logic [7:0] b, input logic stop_bit);
		logic [9:0] frame;
		frame = {stop_bit, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out = frame[i];
			repeat (div) @(posedge clk);
			#1;
		end
		// a cut stop bit is followed by one idle bit
		if (!stop_bit) begin
			line_out = 1'b1;
			repeat (div) @(posedge clk);
			#1;
		end
	endtask

	// ---------------------------------------------------------------
	// receiver, mid-bit sampling
	// ---------------------------------------------------------------
	always begin
		@(negedge line_in);
		repeat (div / 2) @(posedge clk);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (div) @(posedge clk);
				rx_byte[i] = line_in;
			end
			repeat (div) @(posedge clk);
			if (line_in !== 1'b1)
				stop_errs++;
			got_q.push_back(rx_byte);
		end
	end
endmodule

// [dasp_top.sv]
/*
 * Two independent full-duplex asynchronous serial ports, each with a
 * single-byte path and a background receive buffer, plus the download
 * hand-over of the first port.
 * Assumes rx lines already synchronous to clk; rst is synchronous.
 */
`timescale 1ns/1ps

// Overview of operation
// - There are two independent ports, each with its own transmit and receive running at once.
// - Every character is eight data bits, no parity and one stop bit, on both ends.
// - Each port has its own bit period setting, spanning 300 baud to 256K baud.
// - A frame begins with a low start bit and ends with a high stop bit around the data.
// - Data bits go out and come in least significant bit first.
// - Software may send and take one byte at a time.
// - In buffered mode received bytes are queued in the background without polling.
// - Port a serves the loader until the application starts, then belongs to the application.
module dasp_port #(
	parameter int unsigned DEPTH = dasp_pkg::RX_DEPTH
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire dasp_pkg::dasp_cfg_type     cfg,
	input  wire logic                       tx_valid,
	output logic                            tx_ready,
	input  wire logic [7:0]                 tx_data,
	output logic                            rx_valid,
	input  wire logic                       rx_ready,
	output logic [7:0]                      rx_data,
	output dasp_pkg::dasp_status_type       status,
	output logic                            txd,
	input  wire logic                       rxd
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [dasp_pkg::DIV_W-1:0] clamp_div(input logic [dasp_pkg::DIV_W-1:0] d);
		if (d < dasp_pkg::DIV_MIN)
			return dasp_pkg::DIV_MIN;
		else if (d > dasp_pkg::DIV_MAX)
			return dasp_pkg::DIV_MAX;
		else
			return d;
	endfunction

	logic [dasp_pkg::DIV_W-1:0] div;
	assign div = clamp_div(cfg.baud_div);

	// ---------------------------------------------------------------
	// transmitter
	// ---------------------------------------------------------------
	dasp_pkg::dasp_tx_state_type tx_st_ff;
	logic [dasp_pkg::DIV_W-1:0] tx_cnt_ff;
	logic [2:0]                 tx_bit_ff;
	logic [7:0]                 tx_sh_ff;
	logic                       txd_ff;
	logic                       tx_tick;

	// compare with >= so a bit period shortened mid-frame cannot wrap the counter
	assign tx_tick  = (tx_cnt_ff >= div - 1'b1);
	assign tx_ready = (tx_st_ff == dasp_pkg::DASP_TX_IDLE);
	assign txd      = txd_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_st_ff  <= dasp_pkg::DASP_TX_IDLE;
			tx_cnt_ff <= '0;
			tx_bit_ff <= 3'h0;
			tx_sh_ff  <= 8'h00;
			txd_ff    <= dasp_pkg::LINE_IDLE;
		end else begin
			tx_cnt_ff <= (tx_st_ff == dasp_pkg::DASP_TX_IDLE || tx_tick) ? '0 : tx_cnt_ff + 1'b1;
			unique case (tx_st_ff)
				dasp_pkg::DASP_TX_IDLE: begin
					txd_ff <= dasp_pkg::LINE_IDLE;
					if (tx_valid) begin
						tx_sh_ff <= tx_data;
						txd_ff   <= dasp_pkg::START_LEVEL;
						tx_st_ff <= dasp_pkg::DASP_TX_START;
					end
				end
				dasp_pkg::DASP_TX_START: begin
					if (tx_tick) begin
						txd_ff    <= tx_sh_ff[0];
						tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
						tx_bit_ff <= 3'h0;
						tx_st_ff  <= dasp_pkg::DASP_TX_DATA;
					end
				end
				dasp_pkg::DASP_TX_DATA: begin
					if (tx_tick) begin
						if (tx_bit_ff == 3'h7) begin
							txd_ff   <= dasp_pkg::STOP_LEVEL;
							tx_st_ff <= dasp_pkg::DASP_TX_STOP;
						end else begin
							txd_ff    <= tx_sh_ff[0];
							tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
							tx_bit_ff <= tx_bit_ff + 3'h1;
						end
					end
				end
				dasp_pkg::DASP_TX_STOP: begin
					if (tx_tick)
						tx_st_ff <= dasp_pkg::DASP_TX_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receiver
	// ---------------------------------------------------------------
	dasp_pkg::dasp_rx_state_type rx_st_ff;
	logic [dasp_pkg::DIV_W-1:0] rx_cnt_ff;
	logic [2:0]                 rx_bit_ff;
	logic [7:0]                 rx_sh_ff;
	logic                       rxd_d_ff;
	logic                       rx_done;
	logic                       rx_bad_stop;
	logic                       rx_half;
	logic                       rx_full_tick;

	assign rx_half      = (rx_cnt_ff >= (div >> 1));
	assign rx_full_tick = (rx_cnt_ff >= div - 1'b1);
	assign rx_done      = (rx_st_ff == dasp_pkg::DASP_RX_STOP) && rx_full_tick && rxd == dasp_pkg::STOP_LEVEL;
	assign rx_bad_stop  = (rx_st_ff == dasp_pkg::DASP_RX_STOP) && rx_full_tick && rxd != dasp_pkg::STOP_LEVEL;

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st_ff  <= dasp_pkg::DASP_RX_IDLE;
			rx_cnt_ff <= '0;
			rx_bit_ff <= 3'h0;
			rx_sh_ff  <= 8'h00;
			rxd_d_ff  <= dasp_pkg::LINE_IDLE;
		end else begin
			rxd_d_ff <= rxd;
			unique case (rx_st_ff)
				dasp_pkg::DASP_RX_IDLE: begin
					rx_cnt_ff <= '0;
					if (rxd_d_ff && !rxd)
						rx_st_ff <= dasp_pkg::DASP_RX_START;
				end
				dasp_pkg::DASP_RX_START: begin
					// re-check start level at mid-bit, reject glitches
					if (rx_half) begin
						rx_cnt_ff <= '0;
						rx_bit_ff <= 3'h0;
						rx_st_ff  <= (rxd == dasp_pkg::START_LEVEL) ? dasp_pkg::DASP_RX_DATA
						                                            : dasp_pkg::DASP_RX_IDLE;
					end else
						rx_cnt_ff <= rx_cnt_ff + 1'b1;
				end
				dasp_pkg::DASP_RX_DATA: begin
					// counts now run from bit centre to bit centre
					if (rx_full_tick) begin
						rx_cnt_ff <= '0;
						rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == 3'h7)
							rx_st_ff <= dasp_pkg::DASP_RX_STOP;
					end else
						rx_cnt_ff <= rx_cnt_ff + 1'b1;
				end
				dasp_pkg::DASP_RX_STOP: begin
					if (rx_full_tick) begin
						rx_cnt_ff <= '0;
						rx_st_ff  <= dasp_pkg::DASP_RX_IDLE;
					end else
						rx_cnt_ff <= rx_cnt_ff + 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receive buffer and single-byte holding
	// ---------------------------------------------------------------
	logic [7:0]  mem [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic [AW:0] used;
	logic        buf_full;
	logic        do_push;
	logic        do_pop;
	logic        overflow_ev;
	logic        frame_err_ff;
	logic        overflow_ff;
	logic        cap;

	assign used     = wr_ff - rd_ff;
	assign cap      = cfg.buffered ? 1'b1 : 1'b0;
	// single-byte mode holds exactly one byte
	assign buf_full = cap ? (used == (AW+1)'(DEPTH)) : (used != '0);
	assign rx_valid = (used != '0);
	assign rx_data  = mem[rd_ff[AW-1:0]];
	assign do_pop   = rx_valid && rx_ready;
	assign do_push  = rx_done && (!buf_full || do_pop);
	assign overflow_ev = rx_done && buf_full && !do_pop;

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (do_push)
				wr_ff <= wr_ff + 1'b1;
			if (do_pop)
				rd_ff <= rd_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push)
			mem[wr_ff[AW-1:0]] <= rx_sh_ff;
	end

	// set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_err_ff <= 1'b0;
			overflow_ff  <= 1'b0;
		end else begin
			frame_err_ff <= rx_bad_stop || (frame_err_ff && !cfg.err_clear);
			overflow_ff  <= overflow_ev || (overflow_ff && !cfg.err_clear);
		end
	end

	assign status.frame_err = frame_err_ff;
	assign status.overflow  = overflow_ff;
	assign status.tx_busy   = !tx_ready;
	assign status.rx_count  = 5'(used);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_tx_go;
		tx_ready && tx_valid;
	endsequence

	a_tx_start_bit: assert property (@(posedge clk) disable iff (rst)
		s_tx_go |=> txd == dasp_pkg::START_LEVEL)
		else $error("start bit not driven low");
	a_tx_idle_high: assert property (@(posedge clk) disable iff (rst)
		$past(tx_st_ff) == dasp_pkg::DASP_TX_IDLE && tx_st_ff == dasp_pkg::DASP_TX_IDLE |-> txd)
		else $error("idle line not high");
	a_tx_lsb_first: assert property (@(posedge clk) disable iff (rst)
		tx_st_ff == dasp_pkg::DASP_TX_START && tx_tick |=> txd == $past(tx_sh_ff[0]))
		else $error("first data bit is not bit 0");
	a_tx_stop_bit: assert property (@(posedge clk) disable iff (rst)
		tx_st_ff == dasp_pkg::DASP_TX_STOP |-> txd == dasp_pkg::STOP_LEVEL)
		else $error("stop bit not high");
	a_rx_frame_err: assert property (@(posedge clk) disable iff (rst)
		rx_bad_stop |=> status.frame_err)
		else $error("bad stop bit not flagged");
	a_rx_overflow_flag: assert property (@(posedge clk) disable iff (rst)
		overflow_ev |=> status.overflow && $stable(wr_ff))
		else $error("overflow not flagged or byte written");
	a_rx_push_store: assert property (@(posedge clk) disable iff (rst)
		do_push |=> used == $past(used) + 1'b1 - (AW+1)'($past(do_pop)))
		else $error("received byte not queued");
	a_rx_single_hold: assert property (@(posedge clk) disable iff (rst)
		!cfg.buffered && $stable(cfg.buffered) |-> used <= 1)
		else $error("single-byte mode holds more than one byte");
	a_div_range: assert property (@(posedge clk) disable iff (rst)
		div >= dasp_pkg::DIV_MIN && div <= dasp_pkg::DIV_MAX &&
		(cfg.baud_div < dasp_pkg::DIV_MIN || cfg.baud_div > dasp_pkg::DIV_MAX || div == cfg.baud_div))
		else $error("bit period out of range");
endmodule

module dasp_top (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       app_running,
	input  wire dasp_pkg::dasp_cfg_type     loader_cfg,
	input  wire logic                       loader_tx_valid,
	output logic                            loader_tx_ready,
	input  wire logic [7:0]                 loader_tx_data,
	output logic                            loader_rx_valid,
	input  wire logic                       loader_rx_ready,
	output logic [7:0]                      loader_rx_data,
	input  wire dasp_pkg::dasp_cfg_type     a_cfg,
	input  wire logic                       a_tx_valid,
	output logic                            a_tx_ready,
	input  wire logic [7:0]                 a_tx_data,
	output logic                            a_rx_valid,
	input  wire logic                       a_rx_ready,
	output logic [7:0]                      a_rx_data,
	output dasp_pkg::dasp_status_type       a_status,
	input  wire dasp_pkg::dasp_cfg_type     b_cfg,
	input  wire logic                       b_tx_valid,
	output logic                            b_tx_ready,
	input  wire logic [7:0]                 b_tx_data,
	output logic                            b_rx_valid,
	input  wire logic                       b_rx_ready,
	output logic [7:0]                      b_rx_data,
	output dasp_pkg::dasp_status_type       b_status,
	output logic                            port_a_transmit,
	input  wire logic                       port_a_receive,
	output logic                            port_b_transmit,
	input  wire logic                       port_b_receive
);
	logic                   own_app_ff;
	dasp_pkg::dasp_cfg_type pa_cfg;
	logic                   pa_tx_valid;
	logic                   pa_tx_ready;
	logic [7:0]             pa_tx_data;
	logic                   pa_rx_valid;
	logic                   pa_rx_ready;
	logic [7:0]             pa_rx_data;

	// ownership flips once, then stays with the application
	always_ff @(posedge clk) begin
		if (rst)
			own_app_ff <= 1'b0;
		else if (app_running)
			own_app_ff <= 1'b1;
	end

	assign pa_cfg          = own_app_ff ? a_cfg : loader_cfg;
	assign pa_tx_valid     = own_app_ff ? a_tx_valid : loader_tx_valid;
	assign pa_tx_data      = own_app_ff ? a_tx_data : loader_tx_data;
	assign pa_rx_ready     = own_app_ff ? a_rx_ready : loader_rx_ready;
	assign a_tx_ready      = own_app_ff && pa_tx_ready;
	assign a_rx_valid      = own_app_ff && pa_rx_valid;
	assign a_rx_data       = pa_rx_data;
	assign loader_tx_ready = !own_app_ff && pa_tx_ready;
	assign loader_rx_valid = !own_app_ff && pa_rx_valid;
	assign loader_rx_data  = pa_rx_data;

	// two instances, fully independent
	dasp_port u_port_a (
		.clk      (clk),
		.rst      (rst),
		.cfg      (pa_cfg),
		.tx_valid (pa_tx_valid),
		.tx_ready (pa_tx_ready),
		.tx_data  (pa_tx_data),
		.rx_valid (pa_rx_valid),
		.rx_ready (pa_rx_ready),
		.rx_data  (pa_rx_data),
		.status   (a_status),
		.txd      (port_a_transmit),
		.rxd      (port_a_receive)
	);

	dasp_port u_port_b (
		.clk      (clk),
		.rst      (rst),
		.cfg      (b_cfg),
		.tx_valid (b_tx_valid),
		.tx_ready (b_tx_ready),
		.tx_data  (b_tx_data),
		.rx_valid (b_rx_valid),
		.rx_ready (b_rx_ready),
		.rx_data  (b_rx_data),
		.status   (b_status),
		.txd      (port_b_transmit),
		.rxd      (port_b_receive)
	);

	a_loader_handover: assert property (@(posedge clk) disable iff (rst)
		app_running |=> a_tx_ready == pa_tx_ready && !loader_tx_ready)
		else $error("port a not handed to application");
endmodule

// [dual_async_serial_ports_test.sv]
/* self-checking bench for the dual serial port block with a peer
   model on each port. assumes one 100 MHz clock. */
`timescale 1ns/1ps
module dual_async_serial_ports_test;
	logic                      clk, rst, app_running;
	dasp_pkg::dasp_cfg_type    loader_cfg, a_cfg, b_cfg;
	logic                      loader_tx_valid, loader_tx_ready, loader_rx_valid, loader_rx_ready;
	logic                      a_tx_valid, a_tx_ready, a_rx_valid, a_rx_ready;
	logic                      b_tx_valid, b_tx_ready, b_rx_valid, b_rx_ready;
	logic [7:0]                loader_tx_data, loader_rx_data, a_tx_data, a_rx_data, b_tx_data, b_rx_data;
	dasp_pkg::dasp_status_type a_status, b_status;
	logic                      port_a_transmit, port_a_receive, port_b_transmit, port_b_receive;
	int                        err_count = 0;
	int                        checks_done = 0;
	logic [7:0]                tx_exp_a[$], tx_exp_b[$], rx_exp_a[$], rx_exp_b[$];

	dasp_top dut_u (.clk(clk), .rst(rst), .app_running(app_running), .loader_cfg(loader_cfg),
		.loader_tx_valid(loader_tx_valid), .loader_tx_ready(loader_tx_ready),
		.loader_tx_data(loader_tx_data), .loader_rx_valid(loader_rx_valid),
		.loader_rx_ready(loader_rx_ready), .loader_rx_data(loader_rx_data), .a_cfg(a_cfg),
		.a_tx_valid(a_tx_valid), .a_tx_ready(a_tx_ready), .a_tx_data(a_tx_data),
		.a_rx_valid(a_rx_valid), .a_rx_ready(a_rx_ready), .a_rx_data(a_rx_data),
		.a_status(a_status), .b_cfg(b_cfg), .b_tx_valid(b_tx_valid), .b_tx_ready(b_tx_ready),
		.b_tx_data(b_tx_data), .b_rx_valid(b_rx_valid), .b_rx_ready(b_rx_ready),
		.b_rx_data(b_rx_data), .b_status(b_status), .port_a_transmit(port_a_transmit),
		.port_a_receive(port_a_receive), .port_b_transmit(port_b_transmit),
		.port_b_receive(port_b_receive));
	dasp_serial_peer peer_a (.clk(clk), .line_in(port_a_transmit), .line_out(port_a_receive));
	dasp_serial_peer peer_b (.clk(clk), .line_in(port_b_transmit), .line_out(port_b_receive));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic bail(input string what);
		$display("[FAIL] %s expected done seen timeout", what);
		err_count++;
		finish_test();
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	// 0 loader, 1 application side of port a, 2 port b
	task automatic dev_send(input int p, input logic [7:0] b);
		int n;
		n = 0;
		while ((p == 0 ? loader_tx_ready : p == 1 ? a_tx_ready : b_tx_ready) !== 1'b1 && n < 9000) begin
			tick(1);
			n++;
		end
		if (n == 9000)
			bail("tx ready");
		loader_tx_data = b;
		a_tx_data = b;
		b_tx_data = b;
		loader_tx_valid = (p == 0);
		a_tx_valid = (p == 1);
		b_tx_valid = (p == 2);
		if (p == 2)
			tx_exp_b.push_back(b);
		else
			tx_exp_a.push_back(b);
		tick(1);
		check("tx busy", 1, p == 2 ? b_status.tx_busy : a_status.tx_busy);
		loader_tx_valid = 1'b0;
		a_tx_valid = 1'b0;
		b_tx_valid = 1'b0;
		tick(1);
	endtask

	task automatic dev_recv(input int p);
		int n;
		logic [7:0] exp;
		n = 0;
		while ((p == 0 ? loader_rx_valid : p == 1 ? a_rx_valid : b_rx_valid) !== 1'b1 && n < 9000) begin
			tick(1);
			n++;
		end
		if (n == 9000)
			bail("rx valid");
		exp = (p == 2) ? rx_exp_b.pop_front() : rx_exp_a.pop_front();
		check("rx data", exp, p == 0 ? loader_rx_data : p == 1 ? a_rx_data : b_rx_data);
		loader_rx_ready = (p == 0);
		a_rx_ready = (p == 1);
		b_rx_ready = (p == 2);
		tick(1);
		loader_rx_ready = 1'b0;
		a_rx_ready = 1'b0;
		b_rx_ready = 1'b0;
		tick(1);
	endtask

	task automatic peer_send(input int p, input logic [7:0] b, input logic stop_bit);
		if (p == 1)
			peer_b.send_byte(b, stop_bit);
		else
			peer_a.send_byte(b, stop_bit);
		if (stop_bit && p == 1)
			rx_exp_b.push_back(b);
		else if (stop_bit)
			rx_exp_a.push_back(b);
	endtask

	task automatic peer_cmp(input int p);
		int n;
		n = 0;
		while ((p == 1 ? peer_b.got_q.size() : peer_a.got_q.size()) == 0 && n < 9000) begin
			tick(1);
			n++;
		end
		if (n == 9000)
			bail("peer byte");
		if (p == 1)
			check("peer b byte", tx_exp_b.pop_front(), peer_b.got_q.pop_front());
		else
			check("peer a byte", tx_exp_a.pop_front(), peer_a.got_q.pop_front());
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge clk);
		bail("whole run");
	end

	initial begin
		void'($urandom(32'hc33f));
		rst = 1'b1;
		app_running = 1'b0;
		{loader_tx_valid, loader_rx_ready, a_tx_valid, a_rx_ready, b_tx_valid, b_rx_ready} = '0;
		{loader_tx_data, a_tx_data, b_tx_data} = '0;
		loader_cfg = '{baud_div: 20'd390, buffered: 1'b0, err_clear: 1'b0};
		a_cfg = loader_cfg;
		b_cfg = '{baud_div: 20'd500, buffered: 1'b1, err_clear: 1'b0};
		peer_b.div = 500;
		tick(2);
		rst = 1'b0;
		check("idle line a", 1, port_a_transmit);
		check("idle line b", 1, port_b_transmit);
		check("loader tx ready", 1, loader_tx_ready);
		check("app tx ready", 0, a_tx_ready);
		fork
			dev_send(0, 8'($urandom()));
			peer_send(0, 8'($urandom()), 1'b1);
		join
		dev_recv(0);
		peer_cmp(0);
		app_running = 1'b1;
		tick(1);
		check("loader ready after start", 0, loader_tx_ready);
		check("app ready after start", 1, a_tx_ready);
		fork
			dev_send(1, 8'($urandom()));
			peer_send(0, 8'($urandom()), 1'b1);
		join
		dev_recv(1);
		peer_cmp(0);
		fork
			begin
				dev_send(2, 8'($urandom()));
				dev_send(2, 8'($urandom()));
			end
			for (int i = 0; i < 3; i++)
				peer_send(1, 8'($urandom()), 1'b1);
		join
		tick(2);
		check("b queued", 3, b_status.rx_count);
		repeat (3) dev_recv(2);
		peer_cmp(1);
		peer_cmp(1);
		peer_send(1, 8'h5a, 1'b0);
		tick(2);
		check("b frame error", 1, b_status.frame_err);
		check("b bad byte dropped", 0, b_rx_valid);
		b_cfg.err_clear = 1'b1;
		tick(1);
		b_cfg.err_clear = 1'b0;
		tick(1);
		check("b frame error cleared", 0, b_status.frame_err);
		peer_send(0, 8'($urandom()), 1'b1);
		peer_send(0, 8'($urandom()), 1'b1);
		// single-byte hold keeps the first, the second is lost
		void'(rx_exp_a.pop_back());
		tick(2);
		check("a overflow", 1, a_status.overflow);
		check("a held count", 1, a_status.rx_count);
		dev_recv(1);
		a_cfg.err_clear = 1'b1;
		tick(1);
		a_cfg.err_clear = 1'b0;
		tick(1);
		check("a overflow cleared", 0, a_status.overflow);
		check("peer a stop bits", 0, peer_a.stop_errs);
		check("peer b stop bits", 0, peer_b.stop_errs);
		finish_test();
	end
endmodule
